// [verilog/ptp_pkg.sv]
// package: register map, field layout, resets and frame carrier of the ptp receive filter
package ptp_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NPORT  = 3;
  localparam int NGROUP = 5;
  localparam int CNT_W  = 3;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_GLOBAL_CTL  = 12'h100;
  localparam logic [11:0] ADDR_BANK_PORT   = 12'h104;
  localparam logic [11:0] ADDR_STAMP_IRQ   = 12'h108;
  localparam logic [11:0] ADDR_MAC_LOW     = 12'h110;
  localparam logic [11:0] ADDR_MAC_HIGH    = 12'h114;
  localparam logic [11:0] ADDR_PARSE_EN    = 12'h158;
  localparam logic [11:0] ADDR_CAP_COUNTS  = 12'h160;

  // ---------------------------------------------------------------
  // bank codes and field positions
  // ---------------------------------------------------------------
  localparam logic [2:0] BANK_GENERAL = 3'h0;
  localparam logic [2:0] BANK_RX      = 3'h1;
  localparam int BANK_LSB       = 0;
  localparam int PORT_SEL_LSB   = 4;
  localparam int TX_CNT_LSB     = 4;
  localparam int RX_CNT_LSB     = 0;
  localparam int RX_IRQ_LSB     = 0;
  localparam int TX_IRQ_LSB     = 8;
  localparam int EN_L2_A        = 14;
  localparam int EN_L2_B        = 13;
  localparam int EN_GROUP_LSB   = 8;
  localparam int EN_L2_CUSTOM   = 7;
  localparam int EN_V6_CUSTOM   = 6;
  localparam int EN_V4_CUSTOM   = 5;
  localparam logic [14:0] PARSE_EN_MASK  = 15'h7fe0;
  localparam logic [14:0] PARSE_EN_RESET = 15'h7100;

  // ---------------------------------------------------------------
  // fixed destination addresses
  // ---------------------------------------------------------------
  localparam logic [47:0] MAC_L2_A       = 48'h0180c200000e;
  localparam logic [47:0] MAC_L2_B       = 48'h011b19000000;
  localparam logic [23:0] V4_MAC_PREFIX  = 24'h01005e;
  localparam logic [23:0] V6_MAC_PREFIX  = 24'h333300;
  localparam logic [15:0] V4_IP_PREFIX   = 16'he000;
  localparam logic [7:0]  V6_IP_PREFIX   = 8'hff;
  localparam logic [3:0]  V6_LINK_SCOPE  = 4'h2;
  // group suffixes, entry i is enabled by parse bit 8+i
  localparam logic [NGROUP-1:0][23:0] GROUP_SUFFIX = {
    24'h000181, 24'h000182, 24'h000183, 24'h000184, 24'h00006b};
  // entries whose ipv6 scope nibble must match exactly
  localparam logic [NGROUP-1:0] GROUP_FIXED_SCOPE = 5'h01;

  // ---------------------------------------------------------------
  // received frame descriptor
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FRAME_L2,
    FRAME_IPV4,
    FRAME_IPV6,
    FRAME_OTHER
  } frame_kind_t;

  typedef struct packed {
    logic        valid;
    frame_kind_t kind;
    logic [47:0] dst_mac;
    logic [127:0] dst_ip;  // ipv4 address in bits 31:0
  } rx_frame_t;

endpackage

// [verilog/ptp_rx_address_filter_and_ts_count.sv]
// module: ptp receive destination filter and pending timestamp counts with apb registers
//
// What this block does
// - per-port 3-bit transmit stamp count in bits 6:4, reset zero
// - count up transmit stamps when a ptp packet leaves the port
// - writing one to a port's transmit irq bit lowers its count
// - per-port 3-bit receive stamp count in bits 2:0, reset zero
// - count up receive stamps when a ptp packet arrives on the port
// - writing one to a port's receive irq bit lowers its count
// - capture count register ignores writes entirely
// - bit 14 (reset one) accepts layer 2 address 01:80:c2:00:00:0e
// - bit 13 (reset one) accepts layer 2 address 01:1b:19:00:00:00
// - bit 12 (reset one) accepts ipv4 group 224.0.1.129
// - bit 12 also accepts ipv6 ff0x::181 with any scope
// - bit 11 (reset zero) accepts group 224.0.1.130 or ff0x::182
// - bit 10 (reset zero) accepts group 224.0.1.131 or ff0x::183
// - bit 9 (reset zero) accepts group 224.0.1.132 or ff0x::184
// - bit 8 (reset one) accepts group 224.0.0.107 or ff02::6b
// - bit 7 accepts layer 2 frames to the user mac
// - bit 6 accepts ipv6 frames to the user mac
// - bit 5 accepts ipv4 frames to the user mac, held in two registers
// - 3-bit bank select pages the per-port window: 000 general, 001 receive
// - 2-bit port select picks which port's registers are reached
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module ptp_rx_address_filter_and_ts_count (
  input  wire logic                                         pclk,
  input  wire logic                                         presetn,
  input  wire logic                                         psel,
  input  wire logic                                         penable,
  input  wire logic                                         pwrite,
  input  wire logic [11:0]                                  paddr,
  input  wire logic [31:0]                                  pwdata,
  output logic      [31:0]                                  prdata,
  output logic                                              pready,
  output logic                                              pslverr,
  input  wire ptp_pkg::rx_frame_t [ptp_pkg::NPORT-1:0]      rx_frame,
  input  wire logic [ptp_pkg::NPORT-1:0]                    tx_ptp_sent,
  output logic      [ptp_pkg::NPORT-1:0]                    rx_ptp_match,
  output logic                                              stamp_enable
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                               apb_write;
  logic                               apb_read;
  logic [2:0]                         bank_sel;
  logic [1:0]                         port_sel;
  logic                               port_ok;
  logic [31:0]                        custom_mac_low_dword;
  logic [15:0]                        custom_mac_high_word;
  logic [47:0]                        custom_mac;
  logic [ptp_pkg::NPORT-1:0][14:0]    parse_en;
  logic [ptp_pkg::NPORT-1:0][2:0]     rx_stamp_pending_count;
  logic [ptp_pkg::NPORT-1:0][2:0]     tx_stamp_pending_count;
  logic [ptp_pkg::NPORT-1:0]          rx_stamp_irq_bits;
  logic [ptp_pkg::NPORT-1:0]          tx_stamp_irq_bits;
  logic [ptp_pkg::NPORT-1:0]          next_match;
  logic                               addr_mapped;
  logic [31:0]                        next_prdata;

  // ---------------------------------------------------------------
  // apb access decode
  // ---------------------------------------------------------------
  // zero wait state slave: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign apb_write = psel & penable & pwrite;
  assign apb_read  = psel & penable & ~pwrite;
  assign port_ok   = (port_sel < 2'(ptp_pkg::NPORT));
  assign custom_mac = {custom_mac_high_word, custom_mac_low_dword};

  // irq write strobes, one per port, pulse only on the completing write
  always_comb begin
    rx_stamp_irq_bits = '0;
    tx_stamp_irq_bits = '0;
    if (apb_write && paddr == ptp_pkg::ADDR_STAMP_IRQ) begin
      for (int p = 0; p < ptp_pkg::NPORT; p++) begin
        rx_stamp_irq_bits[p] = pwdata[ptp_pkg::RX_IRQ_LSB + p];
        tx_stamp_irq_bits[p] = pwdata[ptp_pkg::TX_IRQ_LSB + p];
      end
    end
  end

  // ---------------------------------------------------------------
  // global registers
  // ---------------------------------------------------------------
  // timestamping enable, software must clear it before changing enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_enable <= 1'b0;
    end else if (apb_write && paddr == ptp_pkg::ADDR_GLOBAL_CTL) begin
      stamp_enable <= pwdata[0];
    end
  end

  // bank and port page select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_sel <= 3'h0;
      port_sel <= 2'h0;
    end else if (apb_write && paddr == ptp_pkg::ADDR_BANK_PORT) begin
      bank_sel <= pwdata[ptp_pkg::BANK_LSB +: 3];
      port_sel <= pwdata[ptp_pkg::PORT_SEL_LSB +: 2];
    end
  end

  // user defined destination mac, shared by all ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      custom_mac_low_dword <= 32'h0;
      custom_mac_high_word <= 16'h0;
    end else if (apb_write) begin
      if (paddr == ptp_pkg::ADDR_MAC_LOW) begin
        custom_mac_low_dword <= pwdata;
      end
      if (paddr == ptp_pkg::ADDR_MAC_HIGH) begin
        custom_mac_high_word <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // per-port logic
  // ---------------------------------------------------------------
  for (genvar p = 0; p < ptp_pkg::NPORT; p++) begin : g_port
    logic                      sel_here;
    logic                      l2_hit;
    logic                      v4_hit;
    logic                      v6_hit;
    logic [ptp_pkg::NGROUP-1:0] grp_hit;
    logic                      rx_inc;
    logic                      rx_dec;
    logic                      tx_dec;
    ptp_pkg::rx_frame_t        f;

    assign f        = rx_frame[p];
    assign sel_here = port_ok && port_sel == 2'(p);

    // parse enables of this port, only reserved-free bits are stored
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        parse_en[p] <= ptp_pkg::PARSE_EN_RESET;
      end else if (apb_write && sel_here && bank_sel == ptp_pkg::BANK_RX &&
                   paddr == ptp_pkg::ADDR_PARSE_EN) begin
        parse_en[p] <= pwdata[14:0] & ptp_pkg::PARSE_EN_MASK;
      end
    end

    // fixed multicast groups, ipv4 and ipv6 share one enable bit each
    for (genvar g = 0; g < ptp_pkg::NGROUP; g++) begin : g_grp
      logic v4_g;
      logic v6_g;
      assign v4_g = f.kind == ptp_pkg::FRAME_IPV4 &&
        f.dst_mac == {ptp_pkg::V4_MAC_PREFIX, ptp_pkg::GROUP_SUFFIX[g]} &&
        f.dst_ip[31:0] == {ptp_pkg::V4_IP_PREFIX, ptp_pkg::GROUP_SUFFIX[g][15:0]};
      // scope nibble is a wildcard except for the link-local group
      assign v6_g = f.kind == ptp_pkg::FRAME_IPV6 &&
        f.dst_mac == {ptp_pkg::V6_MAC_PREFIX, ptp_pkg::GROUP_SUFFIX[g]} &&
        f.dst_ip[127:120] == ptp_pkg::V6_IP_PREFIX &&
        f.dst_ip[119:116] == 4'h0 &&
        (!ptp_pkg::GROUP_FIXED_SCOPE[g] ||
         f.dst_ip[115:112] == ptp_pkg::V6_LINK_SCOPE) &&
        f.dst_ip[111:16] == 96'h0 &&
        f.dst_ip[15:0] == ptp_pkg::GROUP_SUFFIX[g][15:0];
      assign grp_hit[g] = parse_en[p][ptp_pkg::EN_GROUP_LSB + g] & (v4_g | v6_g);
    end

    // fixed layer 2 and user defined mac matches
    assign l2_hit = f.kind == ptp_pkg::FRAME_L2 &&
      ((parse_en[p][ptp_pkg::EN_L2_A] && f.dst_mac == ptp_pkg::MAC_L2_A) ||
       (parse_en[p][ptp_pkg::EN_L2_B] && f.dst_mac == ptp_pkg::MAC_L2_B) ||
       (parse_en[p][ptp_pkg::EN_L2_CUSTOM] && f.dst_mac == custom_mac));
    assign v6_hit = f.kind == ptp_pkg::FRAME_IPV6 &&
      parse_en[p][ptp_pkg::EN_V6_CUSTOM] && f.dst_mac == custom_mac;
    assign v4_hit = f.kind == ptp_pkg::FRAME_IPV4 &&
      parse_en[p][ptp_pkg::EN_V4_CUSTOM] && f.dst_mac == custom_mac;

    // any enabled match marks the frame as ptp
    assign next_match[p] = f.valid & (l2_hit | v4_hit | v6_hit | (|grp_hit));

    // registered one-cycle match pulse
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_ptp_match[p] <= 1'b0;
      end else begin
        rx_ptp_match[p] <= next_match[p];
      end
    end

    assign rx_inc = rx_ptp_match[p] & stamp_enable;
    assign rx_dec = rx_stamp_irq_bits[p];
    assign tx_dec = tx_stamp_irq_bits[p];

    // receive pending count, simultaneous up and down leaves it unchanged
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_stamp_pending_count[p] <= 3'h0;
      end else if (rx_inc && !rx_dec && rx_stamp_pending_count[p] != 3'h7) begin
        rx_stamp_pending_count[p] <= rx_stamp_pending_count[p] + 3'h1;
      end else if (rx_dec && !rx_inc && rx_stamp_pending_count[p] != 3'h0) begin
        rx_stamp_pending_count[p] <= rx_stamp_pending_count[p] - 3'h1;
      end
    end

    // transmit pending count
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_stamp_pending_count[p] <= 3'h0;
      end else if (tx_ptp_sent[p] && stamp_enable && !tx_dec &&
                   tx_stamp_pending_count[p] != 3'h7) begin
        tx_stamp_pending_count[p] <= tx_stamp_pending_count[p] + 3'h1;
      end else if (tx_dec && !(tx_ptp_sent[p] && stamp_enable) &&
                   tx_stamp_pending_count[p] != 3'h0) begin
        tx_stamp_pending_count[p] <= tx_stamp_pending_count[p] - 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // paged registers answer only in their own bank for a present port
  always_comb begin
    next_prdata = 32'h0;
    addr_mapped = 1'b1;
    unique case (paddr)
      ptp_pkg::ADDR_GLOBAL_CTL: next_prdata[0] = stamp_enable;
      ptp_pkg::ADDR_BANK_PORT: begin
        next_prdata[ptp_pkg::BANK_LSB +: 3]     = bank_sel;
        next_prdata[ptp_pkg::PORT_SEL_LSB +: 2] = port_sel;
      end
      ptp_pkg::ADDR_STAMP_IRQ: begin
        for (int p = 0; p < ptp_pkg::NPORT; p++) begin
          next_prdata[ptp_pkg::RX_IRQ_LSB + p] = |rx_stamp_pending_count[p];
          next_prdata[ptp_pkg::TX_IRQ_LSB + p] = |tx_stamp_pending_count[p];
        end
      end
      ptp_pkg::ADDR_MAC_LOW:  next_prdata = custom_mac_low_dword;
      ptp_pkg::ADDR_MAC_HIGH: next_prdata[15:0] = custom_mac_high_word;
      ptp_pkg::ADDR_PARSE_EN: begin
        addr_mapped = port_ok && bank_sel == ptp_pkg::BANK_RX;
        if (addr_mapped) begin
          next_prdata[14:0] = parse_en[port_sel];
        end
      end
      ptp_pkg::ADDR_CAP_COUNTS: begin
        addr_mapped = port_ok && bank_sel == ptp_pkg::BANK_GENERAL;
        if (addr_mapped) begin
          next_prdata[ptp_pkg::TX_CNT_LSB +: 3] = tx_stamp_pending_count[port_sel];
          next_prdata[ptp_pkg::RX_CNT_LSB +: 3] = rx_stamp_pending_count[port_sel];
        end
      end
      default: addr_mapped = 1'b0;
    endcase
  end

  // read data and error are combinational on the access cycle
  always_comb begin
    prdata  = apb_read ? next_prdata : 32'h0;
    pslverr = psel & penable & ~addr_mapped; // capture count writes are dropped, without error only in the general bank for a present port
  end

endmodule

// [dv/ptp_checker.sv]
// checker: apb and frame-path properties of the ptp receive filter
`timescale 1ns/10ps
module ptp_checker (
  input wire logic                                    pclk,
  input wire logic                                    presetn,
  input wire logic                                    psel,
  input wire logic                                    penable,
  input wire logic                                    pwrite,
  input wire logic [11:0]                             paddr,
  input wire logic [31:0]                             pwdata,
  input wire logic [31:0]                             prdata,
  input wire logic                                    pready,
  input wire logic                                    pslverr,
  input wire ptp_pkg::rx_frame_t [ptp_pkg::NPORT-1:0] rx_frame,
  input wire logic [ptp_pkg::NPORT-1:0]               tx_ptp_sent,
  input wire logic [ptp_pkg::NPORT-1:0]               rx_ptp_match,
  input wire logic                                    stamp_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // helper decodes
  // ---------------------------------------------------------------
  logic [ptp_pkg::NPORT-1:0] vld, oth;
  logic                      acc, rd, ctl_wr;
  always_comb begin
    for (int i = 0; i < ptp_pkg::NPORT; i++) begin
      vld[i] = rx_frame[i].valid;
      oth[i] = rx_frame[i].valid && rx_frame[i].kind == ptp_pkg::FRAME_OTHER;
    end
  end
  assign acc    = psel && penable;
  assign rd     = acc && !pwrite;
  assign ctl_wr = acc && pwrite && paddr == ptp_pkg::ADDR_GLOBAL_CTL;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  zero_wait_a: assert property (acc |-> pready)
    else $error("access not answered at once");
  idle_quiet_a: assert property (!acc |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs active outside access");
  cap_reserved_a: assert property (
    rd && paddr == ptp_pkg::ADDR_CAP_COUNTS |-> (prdata & 32'hffffff88) == 32'h0)
    else $error("count register reserved bits set");
  parse_reserved_a: assert property (
    rd && paddr == ptp_pkg::ADDR_PARSE_EN |-> (prdata & 32'hffff801f) == 32'h0)
    else $error("enable register reserved bits set");
  irq_reserved_a: assert property (
    rd && paddr == ptp_pkg::ADDR_STAMP_IRQ |-> (prdata & 32'hfffff8f8) == 32'h0)
    else $error("irq register reserved bits set");
  unmapped_err_a: assert property (acc && !(paddr inside {12'h100, 12'h104,
    12'h108, 12'h110, 12'h114, 12'h158, 12'h160}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  match_cause_a: assert property (|rx_ptp_match |-> (rx_ptp_match & ~$past(vld)) == 3'h0)
    else $error("match without frame");
  other_refused_a: assert property (|oth |=> (rx_ptp_match & $past(oth)) == 3'h0)
    else $error("foreign frame matched");
  enable_write_a: assert property (ctl_wr |=> stamp_enable == $past(pwdata[0]))
    else $error("enable not taken from write");
  enable_hold_a: assert property (!ctl_wr |=> $stable(stamp_enable))
    else $error("enable changed without write");
  cover property (|rx_ptp_match);
  cover property (rd && paddr == ptp_pkg::ADDR_CAP_COUNTS && prdata[6:4] == 3'h7);
  cover property (acc && pslverr);
  cover property ($rose(stamp_enable));
endmodule

bind ptp_rx_address_filter_and_ts_count ptp_checker ptp_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_frame(rx_frame), .tx_ptp_sent(tx_ptp_sent), .rx_ptp_match(rx_ptp_match),
  .stamp_enable(stamp_enable));

// [dv/ptp_port_model.sv]
// model: port frame receive and transmit paths feeding the ptp filter
`timescale 1ns/10ps
module ptp_port_model (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               go,
  input  wire logic [1:0]                         port,
  input  wire ptp_pkg::rx_frame_t                 frm,
  input  wire logic [2:0]                         tx,
  output ptp_pkg::rx_frame_t [ptp_pkg::NPORT-1:0] rx_frame,
  output logic [2:0]                              tx_ptp_sent
);
  // ---------------------------------------------------------------
  // frame slots: idle fields toggle so stale values never look valid
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame    <= '0;
      tx_ptp_sent <= 3'h0;
    end else begin
      for (int i = 0; i < ptp_pkg::NPORT; i++) begin
        rx_frame[i] <= (go && port == i) ? frm : {1'b0, ~rx_frame[i][177:0]};
      end
      tx_ptp_sent <= tx;
    end
  end
endmodule

// [dv/ptp_rx_address_filter_and_ts_count_tb.sv]
// testbench: apb and frame-path tests of the ptp receive filter
`timescale 1ns/10ps
module ptp_rx_address_filter_and_ts_count_tb;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, f_go = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, stamp_enable;
  logic [1:0] f_port = 2'h0;
  logic [2:0] f_tx = 3'h0, tx_ptp_sent, rx_ptp_match;
  ptp_pkg::rx_frame_t f_frm = '0;
  ptp_pkg::rx_frame_t [ptp_pkg::NPORT-1:0] rx_frame;
  logic [4:0][23:0] sfx = {24'h000181, 24'h000182, 24'h000183, 24'h000184, 24'h00006b};
  int fail_count = 0, n_compared = 0, cycles = 0;
  ptp_rx_address_filter_and_ts_count ptp_rx_address_filter_and_ts_count_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .tx_ptp_sent(tx_ptp_sent), .rx_ptp_match(rx_ptp_match),
    .stamp_enable(stamp_enable));
  ptp_port_model ptp_port_model_inst (.pclk(pclk), .presetn(presetn), .go(f_go),
    .port(f_port), .frm(f_frm), .tx(f_tx), .rx_frame(rx_frame), .tx_ptp_sent(tx_ptp_sent));
  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task finish_test;
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // bus and frame tasks
  // ---------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0); `CHK(r, x) `CHK(e, xe)
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d); `CHK(e, 1'b0)
  endtask
  task sel(input logic [2:0] bank, input logic [1:0] port);
    wr(ptp_pkg::ADDR_BANK_PORT, {26'h0, port, 1'b0, bank});
  endtask
  task send(input logic [1:0] p, input ptp_pkg::frame_kind_t k, input logic [47:0] m,
            input logic [127:0] ip, input logic [2:0] tx, input logic [2:0] x);
    f_port <= p; f_frm <= {1'b1, k, m, ip}; f_tx <= tx; f_go <= 1'b1;
    @(posedge pclk); f_go <= 1'b0; f_tx <= 3'h0;
    @(posedge pclk); #1;
    `CHK(rx_ptp_match, x)
    @(posedge pclk);
  endtask
  // one enable alone must accept the frame, all others together must not
  task try(input int b, input ptp_pkg::frame_kind_t k, input logic [47:0] m,
           input logic [127:0] ip);
    wr(ptp_pkg::ADDR_PARSE_EN, 32'h1 << b); send(2'h0, k, m, ip, 3'h0, 3'h1);
    wr(ptp_pkg::ADDR_PARSE_EN, 32'h7fe0 & ~(32'h1 << b)); send(2'h0, k, m, ip, 3'h0, 3'h0);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int p = 0; p < 3; p++) begin
      sel(ptp_pkg::BANK_RX, p[1:0]); rd(ptp_pkg::ADDR_PARSE_EN, 32'h7100, 1'b0);
      sel(ptp_pkg::BANK_GENERAL, p[1:0]); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b0);
    end
    sel(ptp_pkg::BANK_GENERAL, 2'h3); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b1);
    rd(ptp_pkg::ADDR_PARSE_EN, 32'h0, 1'b1);
    sel(3'h2, 2'h0); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b1);
    rd(12'h10c, 32'h0, 1'b1);
    sel(ptp_pkg::BANK_RX, 2'h0);
    wr(ptp_pkg::ADDR_MAC_LOW, 32'h3c4d5e6f); wr(ptp_pkg::ADDR_MAC_HIGH, 32'h1a2b);
    try(14, ptp_pkg::FRAME_L2, 48'h0180c200000e, 128'h0);
    try(13, ptp_pkg::FRAME_L2, 48'h011b19000000, 128'h0);
    for (int g = 0; g < 5; g++) begin
      // entry g of the suffix list is enabled by parse bit 8+g, entry 0 is link-local only
      try(8 + g, ptp_pkg::FRAME_IPV4, {24'h01005e, sfx[g]}, {96'h0, 8'he0, sfx[g]});
      try(8 + g, ptp_pkg::FRAME_IPV6, {24'h333300, sfx[g]},
          {12'hff0, (g == 0) ? 4'h2 : 4'h5, 96'h0, sfx[g][15:0]});
    end
    wr(ptp_pkg::ADDR_PARSE_EN, 32'h7fe0);
    send(2'h0, ptp_pkg::FRAME_IPV6, 48'h33330000006b, {16'hff05, 96'h0, 16'h006b}, 3'h0, 3'h0);
    send(2'h0, ptp_pkg::FRAME_OTHER, 48'h0180c200000e, 128'h0, 3'h0, 3'h0);
    try(7, ptp_pkg::FRAME_L2, 48'h1a2b3c4d5e6f, 128'h0);
    try(6, ptp_pkg::FRAME_IPV6, 48'h1a2b3c4d5e6f, 128'h0);
    try(5, ptp_pkg::FRAME_IPV4, 48'h1a2b3c4d5e6f, 128'h0);
    sel(ptp_pkg::BANK_GENERAL, 2'h0); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b0);
    wr(ptp_pkg::ADDR_GLOBAL_CTL, 32'h1);
    repeat (9) send(2'h1, ptp_pkg::FRAME_L2, 48'h0180c200000e, 128'h0, 3'h2, 3'h2);
    sel(ptp_pkg::BANK_GENERAL, 2'h1); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h77, 1'b0);
    rd(ptp_pkg::ADDR_STAMP_IRQ, 32'h0202, 1'b0);
    wr(ptp_pkg::ADDR_STAMP_IRQ, 32'h2); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h76, 1'b0);
    wr(ptp_pkg::ADDR_STAMP_IRQ, 32'h200); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h66, 1'b0);
    wr(ptp_pkg::ADDR_CAP_COUNTS, 32'hffffffff); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h66, 1'b0);
    sel(ptp_pkg::BANK_GENERAL, 2'h2); rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b0);
    sel(ptp_pkg::BANK_GENERAL, 2'h1);
    repeat (7) wr(ptp_pkg::ADDR_STAMP_IRQ, 32'h202);
    rd(ptp_pkg::ADDR_CAP_COUNTS, 32'h0, 1'b0);
    rd(ptp_pkg::ADDR_STAMP_IRQ, 32'h0, 1'b0);
    finish_test();
  end
endmodule
